// ===== design/phc_packet_handler.sv
// packet handler: register file, receive framer and transmit bit source
// How it works
// - sync_word_low byte, reset 0x91, forms low half of hunted sync word.
// - fixed mode takes packet length from packet_length_limit, reset 0xff.
// - variable mode drops packets whose length byte exceeds packet_length_limit.
// - estimator counts up one on bit change, down eight on repeat.
// - sync accepted only when estimator reaches four times threshold; zero accepts all.
// - flush_on_bad_check empties receive storage after failed check sum.
// - bytes_a appends rssi byte and check-result/lqi byte to each packet.
// - address_filter_mode picks none, exact, zero broadcast, or zero and ones broadcast.
// - whitening_enable bit six whitens transmit and dewhitens receive data.
// - data_path_format 00 moves data through receive storage and transmit register.
// - data_path_format 01 takes transmit bits from general_output_pin_zero.
// - data_path_format 10 sends pseudo-random sequence; receive as in 00.
// - data_path_format 11 takes transmit from pin zero, drives receive bits out.
// - check sum sent on transmit and checked on receive only when enabled.
// - length setting 00 selects fixed length packets.
// - length setting 01, after reset, selects variable length packets.
// - variable length taken from first byte after the sync word.
// - length setting 10 receives without end; setting 11 receives nothing.
// - address compared with device address; broadcast values 0x00 and 0xff.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module phc_packet_handler
  import phc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  sync_word_high,
  input  wire logic [7:0]  rssi_value,
  input  wire logic [6:0]  lqi_value,
  input  wire logic        rx_bit,
  input  wire logic        rx_bit_valid,
  input  wire logic        tx_bit_req,
  input  wire logic        general_output_pin_zero,
  output logic             tx_bit,
  output logic             tx_bit_valid,
  output logic             rx_serial_out,
  output logic             sync_detected
);
  typedef struct packed {
    logic [7:0]  sync_low;
    logic [7:0]  pkt_len;
    logic [7:0]  dev_addr;
    logic [2:0]  preamble_quality_threshold;
    logic        autoflush;
    logic        append;
    logic [1:0]  address_filter_mode;
    logic        white;
    logic [1:0]  fmt;
    logic        crc_en;
    logic [1:0]  len_cfg;
    logic        rx_en;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    phc_state_t  st;
    logic [15:0] sh;
    logic        last;
    logic [2:0]  bitcnt;
    logic [7:0]  pqi;
    logic [7:0]  left;
    logic [15:0] crc;
    logic [8:0]  pn;
    logic        chk2;
    logic [6:0]  wr;
    logic [6:0]  rd;
    logic [6:0]  start;
    logic        crc_ok;
    logic        ovf;
    logic        sync_hit;
    logic        pin_s1;
    logic        pin_s2;
    logic [7:0]  txsh;
    logic [3:0]  txcnt;
    logic [15:0] txcrc;
    logic [8:0]  txpn;
    logic [1:0]  txph;
    logic        txbit;
    logic        txval;
    logic        ser;
  } phc_regs_t;

  phc_regs_t   r_reg;
  phc_regs_t   r_next;
  logic        mem_we;
  logic [7:0]  mem_rdata;
  logic        push;
  logic [7:0]  push_d;
  logic        dbit;
  logic [7:0]  rbyte;
  logic        bdone;
  logic        addr_ok;
  logic [15:0] crc_nx;
  logic [6:0]  count;
  logic [5:0]  idx;
  logic        hit;
  logic        acc;
  logic        done;
  logic [31:0] rdv;
  phc_state_t  tail;

  phc_rx_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (mem_we),
    .waddr   (r_reg.wr[5:0]),
    .wdata   (push_d),
    .raddr   (r_reg.rd[5:0]),
    .rdata   (mem_rdata)
  );

  // helper terms shared by receive and bus logic
  always_comb begin
    idx     = paddr[7:2];
    acc     = psel & penable;
    done    = acc & r_reg.pready;
    count   = r_reg.wr - r_reg.rd;
    dbit    = r_reg.white ? (rx_bit ^ r_reg.pn[0]) : rx_bit;
    rbyte   = {r_reg.sh[6:0], dbit};
    bdone   = rx_bit_valid && (r_reg.bitcnt == 3'd7);
    crc_nx  = crc_step(r_reg.crc, dbit);
    addr_ok = (rbyte == r_reg.dev_addr) || (r_reg.address_filter_mode[1] && rbyte == BCAST_ZERO) ||
              (r_reg.address_filter_mode == ADR_BC_BOTH && rbyte == BCAST_ONES);
    tail    = r_reg.crc_en ? ST_CHK : (r_reg.append ? ST_ST1 : ST_HUNT);
    hit     = 1'b1;
    unique case (idx)
      IDX_SYNC_LOW: rdv = {24'h000000, r_reg.sync_low};
      IDX_PKT_LEN:  rdv = {24'h000000, r_reg.pkt_len};
      IDX_CTRL_RX:  rdv = {24'h000000, r_reg.preamble_quality_threshold, 1'b0, r_reg.autoflush, r_reg.append, r_reg.address_filter_mode};
      IDX_CTRL_FMT: rdv = {24'h000000, 1'b0, r_reg.white, r_reg.fmt, 1'b0, r_reg.crc_en, r_reg.len_cfg};
      IDX_DEV_ADDR: rdv = {24'h000000, r_reg.dev_addr};
      IDX_CONTROL:  rdv = {31'h00000000, r_reg.rx_en};
      IDX_STATUS:   rdv = {14'h0000, r_reg.pqi, (r_reg.txcnt != 4'h0), r_reg.crc_ok, r_reg.ovf, count};
      IDX_RX_DATA:  rdv = {24'h000000, mem_rdata};
      IDX_TX_DATA:  rdv = 32'h00000000;
      default: begin
        rdv = 32'h00000000;
        hit = 1'b0;
      end
    endcase
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end
  end

  // next state of the whole block
  always_comb begin
    r_next          = r_reg;
    push            = 1'b0;
    push_d          = rbyte;
    mem_we          = 1'b0;
    r_next.sync_hit = 1'b0;
    r_next.txval    = 1'b0;
    // pin synchroniser
    r_next.pin_s1   = general_output_pin_zero;
    r_next.pin_s2   = r_reg.pin_s1;
    if (rx_bit_valid) begin
      r_next.last = rx_bit;
      if (rx_bit != r_reg.last) begin
        r_next.pqi = (r_reg.pqi == PQI_MAX) ? PQI_MAX : r_reg.pqi + PQI_UP;
      end else begin
        r_next.pqi = (r_reg.pqi < PQI_DOWN) ? 8'h00 : r_reg.pqi - PQI_DOWN;
      end
      if (r_reg.fmt[0]) begin
        r_next.ser = rx_bit;
      end
    end
    // packet receive in modes 00 and 10
    if (!r_reg.rx_en || r_reg.fmt[0]) begin
      r_next.st = ST_HUNT;
    end else if (r_reg.st == ST_ST1) begin
      push      = 1'b1;
      push_d    = rssi_value;
      r_next.st = ST_ST2;
    end else if (r_reg.st == ST_ST2) begin
      push      = 1'b1;
      push_d    = {r_reg.crc_ok, lqi_value};
      r_next.st = ST_HUNT;
    end else if (rx_bit_valid && r_reg.st == ST_HUNT) begin
      r_next.sh = {r_reg.sh[14:0], rx_bit};
      if ({r_reg.sh[14:0], rx_bit} == {sync_word_high, r_reg.sync_low} && r_reg.len_cfg != LEN_RESERVED &&
          (r_reg.preamble_quality_threshold == 3'h0 || r_reg.pqi >= {3'b000, r_reg.preamble_quality_threshold, 2'b00})) begin
        r_next.sync_hit = 1'b1;
        r_next.bitcnt   = 3'd0;
        r_next.crc      = CRC_INIT;
        r_next.pn       = PN9_INIT;
        r_next.chk2     = 1'b0;
        r_next.start    = r_reg.wr;
        r_next.left     = r_reg.pkt_len;
        if (r_reg.len_cfg == LEN_VARIABLE) begin
          r_next.st = ST_LEN;
        end else if (r_reg.address_filter_mode != ADR_NONE) begin
          r_next.st = ST_ADDR;
        end else if (r_reg.len_cfg == LEN_FIXED && r_reg.pkt_len == 8'h00) begin
          r_next.st = tail;
        end else begin
          r_next.st = ST_PAY;
        end
      end
    end else if (rx_bit_valid) begin
      // dewhitening and check sum per bit
      r_next.sh     = {r_reg.sh[14:0], dbit};
      r_next.bitcnt = r_reg.bitcnt + 3'd1;
      r_next.pn     = pn_step(r_reg.pn);
      r_next.crc    = crc_nx;
      if (bdone) begin
        unique case (r_reg.st)
          ST_LEN: begin
            if (rbyte > r_reg.pkt_len) begin
              r_next.st = ST_HUNT;
            end else begin
              push        = 1'b1;
              r_next.left = rbyte;
              if (r_reg.address_filter_mode != ADR_NONE) begin
                r_next.st = ST_ADDR;
              end else begin
                r_next.st = (rbyte == 8'h00) ? tail : ST_PAY;
              end
            end
          end
          ST_ADDR: begin
            if (!addr_ok) begin
              r_next.st = ST_HUNT;
              r_next.wr = r_reg.start;
            end else begin
              push        = 1'b1;
              r_next.left = r_reg.left - 8'h01;
              if (r_reg.len_cfg != LEN_INFINITE && r_reg.left <= 8'h01) begin
                r_next.st = tail;
              end else begin
                r_next.st = ST_PAY;
              end
            end
          end
          ST_PAY: begin
            push        = 1'b1;
            r_next.left = r_reg.left - 8'h01;
            if (r_reg.len_cfg != LEN_INFINITE && r_reg.left == 8'h01) begin
              r_next.st = tail;
            end
          end
          default: begin
            r_next.chk2 = 1'b1;
            if (r_reg.chk2) begin
              r_next.crc_ok = (crc_nx == 16'h0000);
              if (crc_nx != 16'h0000 && r_reg.autoflush) begin
                r_next.wr = r_reg.rd;
                r_next.st = ST_HUNT;
              end else begin
                r_next.st = r_reg.append ? ST_ST1 : ST_HUNT;
              end
            end
          end
        endcase
      end
    end
    // storage write, full storage drops the byte
    if (push) begin
      if (count == FIFO_DEPTH) begin
        r_next.ovf = 1'b1;
      end else begin
        mem_we    = 1'b1;
        r_next.wr = r_reg.wr + 7'd1;
      end
    end
    // transmit bit source
    if (tx_bit_req) begin
      if (r_reg.fmt == FMT_FIFO) begin
        if (r_reg.txcnt != 4'h0) begin
          r_next.txbit = r_reg.txsh[7] ^ (r_reg.white & r_reg.txpn[0]);
          r_next.txval = 1'b1;
          r_next.txsh  = {r_reg.txsh[6:0], 1'b0};
          r_next.txcnt = r_reg.txcnt - 4'h1;
          r_next.txpn  = pn_step(r_reg.txpn);
          // transmit check sum over data bits
          if (r_reg.txph == 2'h0) begin
            r_next.txcrc = crc_step(r_reg.txcrc, r_reg.txsh[7]);
          end
          if (r_reg.txcnt == 4'h1 && r_reg.txph == 2'h2) begin
            r_next.txsh  = r_reg.txcrc[7:0];
            r_next.txcnt = BYTE_BITS;
            r_next.txph  = 2'h1;
          end else if (r_reg.txcnt == 4'h1 && r_reg.txph == 2'h1) begin
            r_next.txph  = 2'h0;
            r_next.txcrc = CRC_INIT;
            r_next.txpn  = PN9_INIT;
          end
        end
      end else if (r_reg.fmt == FMT_RANDOM) begin
        r_next.txbit = r_reg.txpn[0];
        r_next.txval = 1'b1;
        r_next.txpn  = pn_step(r_reg.txpn);
      end else begin
        r_next.txbit = r_reg.pin_s2;
        r_next.txval = 1'b1;
      end
    end
    // bus slave: one wait cycle, then the answer
    r_next.pready  = acc && !r_reg.pready;
    r_next.pslverr = acc && !r_reg.pready && !hit;
    r_next.prdata  = (acc && !r_reg.pready && !pwrite) ? rdv : 32'h00000000;
    if (done && !pwrite && !r_reg.pslverr && idx == IDX_RX_DATA && count != 7'h00) begin
      r_next.rd = r_reg.rd + 7'd1;
    end
    if (done && pwrite && !r_reg.pslverr) begin
      unique case (idx)
        IDX_SYNC_LOW: r_next.sync_low = pwdata[7:0];
        IDX_PKT_LEN:  r_next.pkt_len = pwdata[7:0];
        IDX_CTRL_RX: begin
          r_next.preamble_quality_threshold       = pwdata[POS_PQT +: 3];
          r_next.autoflush = pwdata[POS_AUTOFLUSH];
          r_next.append    = pwdata[POS_APPEND];
          r_next.address_filter_mode   = pwdata[POS_ADDRESS_FILTER_MODE +: 2];
        end
        IDX_CTRL_FMT: begin
          r_next.white   = pwdata[POS_WHITE];
          r_next.fmt     = pwdata[POS_FMT +: 2];
          r_next.crc_en  = pwdata[POS_CRC_EN];
          r_next.len_cfg = pwdata[POS_LEN_CFG +: 2];
        end
        IDX_DEV_ADDR: r_next.dev_addr = pwdata[7:0];
        IDX_CONTROL: begin
          r_next.rx_en = pwdata[POS_RX_EN];
          if (pwdata[POS_RX_FLUSH]) begin
            r_next.wr  = r_reg.rd;
            r_next.ovf = push && (count == FIFO_DEPTH); // overflow set wins over flush
            r_next.st  = ST_HUNT;
          end
          if (r_reg.txcnt == 4'h0 && pwdata[POS_TX_RESTART]) begin
            r_next.txcrc = CRC_INIT;
            r_next.txpn  = PN9_INIT;
          end else if (r_reg.txcnt == 4'h0 && pwdata[POS_SEND_CHECK] && r_reg.crc_en) begin
            r_next.txsh  = r_reg.txcrc[15:8];
            r_next.txcnt = BYTE_BITS;
            r_next.txph  = 2'h2;
          end
        end
        IDX_TX_DATA: begin
          if (r_reg.txcnt == 4'h0) begin
            r_next.txsh  = pwdata[7:0];
            r_next.txcnt = BYTE_BITS;
          end
        end
        default: r_next.rx_en = r_reg.rx_en;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg           <= '0;
      r_reg.sync_low  <= RST_SYNC_LOW;
      r_reg.pkt_len   <= RST_PKT_LEN;
      r_reg.dev_addr  <= RST_DEV_ADDR;
      r_reg.preamble_quality_threshold       <= RST_PQT;
      r_reg.autoflush <= RST_AUTOFLUSH;
      r_reg.append    <= RST_APPEND;
      r_reg.address_filter_mode   <= RST_ADDRESS_FILTER_MODE;
      r_reg.white     <= RST_WHITE;
      r_reg.fmt       <= RST_FMT;
      r_reg.crc_en    <= RST_CRC_EN;
      r_reg.len_cfg   <= RST_LEN_CFG;
      r_reg.st        <= ST_HUNT;
      r_reg.crc       <= CRC_INIT;
      r_reg.pn        <= PN9_INIT;
      r_reg.txcrc     <= CRC_INIT;
      r_reg.txpn      <= PN9_INIT;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign prdata        = r_reg.prdata;
  assign pready        = r_reg.pready;
  assign pslverr       = r_reg.pslverr;
  assign tx_bit        = r_reg.txbit;
  assign tx_bit_valid  = r_reg.txval;
  assign rx_serial_out = r_reg.ser;
  assign sync_detected = r_reg.sync_hit;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sync_low_wr_a: assert property (done && pwrite && !r_reg.pslverr && idx == IDX_SYNC_LOW |=> r_reg.sync_low == $past(pwdata[7:0])) else $error("sync low byte not written");
  bus_answer_a: assert property (acc && !r_reg.pready |=> pready ##1 !pready) else $error("bus answer timing wrong");
  pqi_down_a: assert property (rx_bit_valid && rx_bit == r_reg.last && r_reg.pqi >= PQI_DOWN |=> r_reg.pqi == $past(r_reg.pqi) - PQI_DOWN) else $error("estimator step down wrong");
  pqi_up_a: assert property (rx_bit_valid && rx_bit != r_reg.last && r_reg.pqi != PQI_MAX |=> r_reg.pqi == $past(r_reg.pqi) + PQI_UP) else $error("estimator step up wrong");
  sync_gate_a: assert property (sync_detected |-> $past(r_reg.preamble_quality_threshold) == 3'h0 || $past(r_reg.pqi) >= {3'b000, $past(r_reg.preamble_quality_threshold), 2'b00}) else $error("sync taken below threshold");
  bad_flush_a: assert property (r_reg.rx_en && !r_reg.fmt[0] && r_reg.st == ST_CHK && r_reg.chk2 && bdone && r_reg.autoflush && crc_nx != 16'h0000 |=> r_reg.wr == r_reg.rd && r_reg.st == ST_HUNT) else $error("no flush on bad check");
  status_pair_a: assert property (r_reg.rx_en && !r_reg.fmt[0] && r_reg.st == ST_CHK && r_reg.chk2 && bdone && r_reg.append && (crc_nx == 16'h0000 || !r_reg.autoflush) |=> r_reg.st == ST_ST1 ##1 r_reg.st == ST_ST2) else $error("status bytes not appended");
  addr_drop_a: assert property (r_reg.rx_en && !r_reg.fmt[0] && r_reg.st == ST_ADDR && bdone && !addr_ok |=> r_reg.st == ST_HUNT && r_reg.wr == $past(r_reg.start)) else $error("bad address kept");
  len_limit_a: assert property (r_reg.rx_en && !r_reg.fmt[0] && r_reg.st == ST_LEN && bdone && rbyte > r_reg.pkt_len |=> r_reg.st == ST_HUNT) else $error("over length packet kept");
  random_tx_a: assert property (r_reg.fmt == FMT_RANDOM && tx_bit_req |=> tx_bit_valid && tx_bit == $past(r_reg.txpn[0])) else $error("random bit missing");
  serial_out_a: assert property (r_reg.fmt[0] && rx_bit_valid |=> rx_serial_out == $past(rx_bit)) else $error("serial receive bit missing");
endmodule : phc_packet_handler
`default_nettype wire

// ===== common/phc_pkg.sv
// shared constants, state codes and bit-step functions of the packet handler
package phc_pkg;
  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_SYNC_LOW = 6'h05;
  localparam logic [5:0] IDX_PKT_LEN  = 6'h06;
  localparam logic [5:0] IDX_CTRL_RX  = 6'h07;
  localparam logic [5:0] IDX_CTRL_FMT = 6'h08;
  localparam logic [5:0] IDX_DEV_ADDR = 6'h09;
  localparam logic [5:0] IDX_CONTROL  = 6'h30;
  localparam logic [5:0] IDX_STATUS   = 6'h31;
  localparam logic [5:0] IDX_RX_DATA  = 6'h32;
  localparam logic [5:0] IDX_TX_DATA  = 6'h33;
  // values after reset
  localparam logic [7:0] RST_SYNC_LOW  = 8'h91;
  localparam logic [7:0] RST_PKT_LEN   = 8'hff;
  localparam logic [2:0] RST_PQT       = 3'h0;
  localparam logic       RST_AUTOFLUSH = 1'b0;
  localparam logic       RST_APPEND    = 1'b1;
  localparam logic [1:0] RST_ADDRESS_FILTER_MODE   = 2'h0;
  localparam logic       RST_WHITE     = 1'b1;
  localparam logic [1:0] RST_FMT       = 2'h0;
  localparam logic       RST_CRC_EN    = 1'b1;
  localparam logic [1:0] RST_LEN_CFG   = 2'h1;
  localparam logic [7:0] RST_DEV_ADDR  = 8'h00;
  // field positions in packet_control_rx and packet_control_format
  localparam int POS_PQT       = 5;
  localparam int POS_AUTOFLUSH = 3;
  localparam int POS_APPEND    = 2;
  localparam int POS_ADDRESS_FILTER_MODE   = 0;
  localparam int POS_WHITE     = 6;
  localparam int POS_FMT       = 4;
  localparam int POS_CRC_EN    = 2;
  localparam int POS_LEN_CFG   = 0;
  // field positions in the control register
  localparam int POS_RX_EN      = 0;
  localparam int POS_SEND_CHECK = 1;
  localparam int POS_TX_RESTART = 2;
  localparam int POS_RX_FLUSH   = 3;
  // modes
  localparam logic [1:0] ADR_NONE     = 2'h0;
  localparam logic [1:0] ADR_BC_BOTH  = 2'h3;
  localparam logic [1:0] FMT_FIFO     = 2'h0;
  localparam logic [1:0] FMT_RANDOM   = 2'h2;
  localparam logic [1:0] LEN_FIXED    = 2'h0;
  localparam logic [1:0] LEN_VARIABLE = 2'h1;
  localparam logic [1:0] LEN_INFINITE = 2'h2;
  localparam logic [1:0] LEN_RESERVED = 2'h3;
  localparam logic [7:0] BCAST_ZERO   = 8'h00;
  localparam logic [7:0] BCAST_ONES   = 8'hff;
  // estimator steps
  localparam logic [7:0] PQI_UP   = 8'h01;
  localparam logic [7:0] PQI_DOWN = 8'h08;
  localparam logic [7:0] PQI_MAX  = 8'hff;
  // check sum, whitening and storage
  localparam logic [15:0] CRC_POLY   = 16'h8005;
  localparam logic [15:0] CRC_INIT   = 16'hffff;
  localparam logic [8:0]  PN9_INIT   = 9'h1ff;
  localparam logic [6:0]  FIFO_DEPTH = 7'h40;
  localparam logic [3:0]  BYTE_BITS  = 4'h8;

  typedef enum logic [6:0] {
    ST_HUNT = 7'h01,
    ST_LEN  = 7'h02,
    ST_ADDR = 7'h04,
    ST_PAY  = 7'h08,
    ST_CHK  = 7'h10,
    ST_ST1  = 7'h20,
    ST_ST2  = 7'h40
  } phc_state_t;

  // one bit into the check sum, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
  endfunction : crc_step

  // one step of the nine-bit whitening sequence
  function automatic logic [8:0] pn_step(input logic [8:0] p);
    pn_step = {p[0] ^ p[5], p[8:1]};
  endfunction : pn_step
endpackage : phc_pkg

// ===== design/phc_rx_mem.sv
// receive byte storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module phc_rx_mem
  import phc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       we,
  input  wire logic [5:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [5:0] raddr,
  output logic      [7:0] rdata
);
  typedef struct packed {
    logic [7:0] rdata;
  } phc_mem_regs_t;

  phc_mem_regs_t r_reg;
  phc_mem_regs_t r_next;
  logic [7:0]    store [0:FIFO_DEPTH-1];

  // read port follows the address every cycle
  always_comb begin
    r_next       = r_reg;
    r_next.rdata = store[raddr];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // array has no reset
  always_ff @(posedge pclk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
  end

  assign rdata = r_reg.rdata;
endmodule : phc_rx_mem
`default_nettype wire

// ===== tb/phc_remote.sv
// remote transceiver model: serial bit source for the receive link
`timescale 1ns/100ps
`default_nettype none
module phc_remote (
  input  wire logic pclk,
  output logic      rx_bit,
  output logic      rx_bit_valid
);
  initial begin
    rx_bit       = 1'b0;
    rx_bit_valid = 1'b0;
  end
  // same sync and framing, msb first
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge pclk);
      rx_bit       <= b[i];
      rx_bit_valid <= 1'b1;
      @(posedge pclk);
      rx_bit_valid <= 1'b0;
      rx_bit       <= ~b[i]; // unsampled line moves
      repeat (2) @(posedge pclk);
    end
  endtask : send_byte
endmodule : phc_remote
`default_nettype wire

// ===== tb/phc_packet_handler_bench.sv
// self-checking bench of the packet handler
`timescale 1ns/100ps
`default_nettype none
module phc_packet_handler_bench;
  import phc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_bit, rx_bit_valid;
  logic        sync_detected, tx_bit_req, pin0, tx_bit, tx_bit_valid, ser_out, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          failures, comparisons, syncs;
  phc_remote rem (.pclk(pclk), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid));
  phc_packet_handler dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_word_high(8'hd3), .rssi_value(8'h5a), .lqi_value(7'h33), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .tx_bit_req(tx_bit_req), .general_output_pin_zero(pin0),
    .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .rx_serial_out(ser_out), .sync_detected(sync_detected));
  // clock and sync pulse count
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(negedge pclk) if (sync_detected === 1'b1) syncs++;
  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer; pready looked at mid-cycle, released after its sample edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      complete_run();
    end
    rd  = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // one transmit request, bit judged while valid stands
  task automatic tx_is(input logic e);
    @(posedge pclk);
    tx_bit_req <= 1'b1;
    @(posedge pclk);
    tx_bit_req <= 1'b0;
    @(negedge pclk);
    check({30'h0, tx_bit_valid, tx_bit}, {30'h0, 1'b1, e});
  endtask : tx_is
  // preamble, sync and up to three bytes, then flush-free settle
  task automatic frame(input logic [7:0] pre, input int n, input logic [23:0] b);
    repeat (4) rem.send_byte(pre);
    rem.send_byte(8'hd3);
    rem.send_byte(RST_SYNC_LOW);
    for (int i = 0; i < n; i++) rem.send_byte(b[23-8*i -: 8]);
    repeat (6) @(posedge pclk);
  endtask : frame
  task automatic count_is(input logic [6:0] c);
    apb(1'b0, 8'hc4, 0);
    check({25'h0, rd[6:0]}, {25'h0, c});
  endtask : count_is
  task automatic t_reset();
    apb(1'b0, 8'h14, 0);
    check(rd, 32'h91);
    apb(1'b0, 8'h18, 0);
    check(rd, 32'hff);
    apb(1'b0, 8'h1c, 0);
    check(rd, 32'h04);
    apb(1'b0, 8'h20, 0);
    check(rd, 32'h45);
    apb(1'b0, 8'h00, 0);
    check({31'h0, err}, 32'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_var();
    apb(1'b1, 8'h20, 32'h01);
    apb(1'b1, 8'hc0, 32'h09);
    syncs = 0;
    frame(8'haa, 3, 24'h02a53c);
    check(syncs, 1);
    count_is(7'h05);
    apb(1'b0, 8'hc8, 0);
    check(rd, 32'h02);
    apb(1'b0, 8'hc8, 0);
    check(rd, 32'ha5);
    apb(1'b0, 8'hc8, 0);
    check(rd, 32'h3c);
    apb(1'b0, 8'hc8, 0);
    check(rd, 32'h5a);
    apb(1'b0, 8'hc8, 0);
    check(rd & 32'h7f, 32'h33);
    $display("test variable done");
  endtask : t_var
  task automatic t_adr();
    apb(1'b1, 8'h24, 32'h12);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 8'h1c, 32'h04 | m);
      apb(1'b1, 8'hc0, 32'h09);
      frame(8'haa, 3, 24'h02ff77);
      count_is((m == 0 || m == 3) ? 7'h05 : 7'h00);
    end
    apb(1'b1, 8'hc0, 32'h09);
    frame(8'haa, 3, 24'h021277);
    count_is(7'h05);
    $display("test address done");
  endtask : t_adr
  task automatic t_len();
    apb(1'b1, 8'h1c, 32'h04);
    apb(1'b1, 8'h18, 32'h02);
    apb(1'b1, 8'h20, 32'h00);
    apb(1'b1, 8'hc0, 32'h09);
    frame(8'haa, 2, 24'ha1b200);
    count_is(7'h04);
    apb(1'b1, 8'h20, 32'h01);
    apb(1'b1, 8'hc0, 32'h09);
    frame(8'haa, 3, 24'h03a1b2);
    count_is(7'h00);
    $display("test length done");
  endtask : t_len
  task automatic t_pqt();
    apb(1'b1, 8'h1c, 32'he4);
    apb(1'b1, 8'hc0, 32'h09);
    syncs = 0;
    frame(8'h00, 3, 24'h02a53c);
    check(syncs, 0);
    count_is(7'h00);
    $display("test threshold done");
  endtask : t_pqt
  // whitened byte, random bits, pin bits and serial receive out
  task automatic t_tx();
    logic [8:0] p;
    logic [7:0] b;
    p = PN9_INIT;
    b = 8'hb4;
    apb(1'b1, 8'h20, 32'h40);
    apb(1'b1, 8'hc0, 32'h04);
    apb(1'b1, 8'hcc, 32'hb4);
    for (int i = 7; i >= 0; i--) begin
      tx_is(b[i] ^ p[0]);
      p = {p[0] ^ p[5], p[8:1]};
    end
    apb(1'b0, 8'hc4, 0);
    check({31'h0, rd[9]}, 32'h0);
    apb(1'b1, 8'h20, 32'h20);
    apb(1'b1, 8'hc0, 32'h04);
    p = PN9_INIT;
    for (int i = 0; i < 8; i++) begin
      tx_is(p[0]);
      p = {p[0] ^ p[5], p[8:1]};
    end
    apb(1'b1, 8'h20, 32'h10);
    @(posedge pclk);
    pin0 <= 1'b1;
    repeat (2) @(posedge pclk);
    tx_is(1'b1);
    @(posedge pclk);
    pin0 <= 1'b0;
    repeat (2) @(posedge pclk);
    tx_is(1'b0);
    apb(1'b1, 8'h20, 32'h30);
    rem.send_byte(8'h01);
    check({31'h0, ser_out}, 32'h1);
    rem.send_byte(8'h02);
    check({31'h0, ser_out}, 32'h0);
    $display("test transmit done");
  endtask : t_tx
  // reset, then the scenarios
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; failures = 0; comparisons = 0; syncs = 0;
    tx_bit_req = 1'b0; pin0 = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_var();
    t_adr();
    t_len();
    t_pqt();
    t_tx();
    complete_run();
  end
endmodule : phc_packet_handler_bench
`default_nettype wire
